//--- tb/gsm_operator.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Operator keys, relay disable line and pressure front end
// ----------------------------------------------------------------------------
module gsm_operator (
  input wire logic clk,
  output logic key_select,
  output logic key_up,
  output logic key_down,
  output logic relay_disable_n,
  output logic [15:0] pressure
);
  logic [2:0] keys_reg;

  assign key_select = keys_reg[0];
  assign key_up = keys_reg[1];
  assign key_down = keys_reg[2];

  // Released keys are pulled low and the disable line is pulled high.
  // The chamber starts vented, above the turn-off threshold, so the relay rests off.
  initial begin
    keys_reg = 3'h0;
    relay_disable_n = 1'b1;
    pressure = 16'h00FA;
  end

  // Contacts chatter once on closing, shorter than the filter window.
  task automatic push(input int k);
    @(posedge clk);
    keys_reg[k] <= 1'b1;
    @(posedge clk);
    keys_reg[k] <= 1'b0;
    @(posedge clk);
    keys_reg[k] <= 1'b1;
  endtask

  task automatic lift(input int k);
    @(posedge clk);
    keys_reg[k] <= 1'b0;
  endtask

  task automatic set_p(input logic [15:0] v);
    @(posedge clk);
    pressure <= v;
  endtask

  // Grounding the line asks the gauge to keep its relay off.
  task automatic set_dis(input logic v);
    @(posedge clk);
    relay_disable_n <= v;
  endtask
endmodule

//--- tb/tb_gsm_menu.sv
`timescale 1ns/100ps
`include "gsm_params.svh"

module tb_gsm_menu;
  typedef struct packed {
    logic [15:0] p;
    logic dis_n;
    logic rly;
  } gsm_row_t;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic k_sel, k_up, k_dn, dis_n, rly, ind;
  logic [15:0] p, disp, on_th, off_th, zero, span, step16;
  logic [2:0] step;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  gsm_row_t rows [7] = '{'{16'h0096, 1'b1, 1'b0}, '{16'h0032, 1'b1, 1'b1},
    '{16'h0096, 1'b1, 1'b1}, '{16'h00FA, 1'b1, 1'b0}, '{16'h0096, 1'b1, 1'b0},
    '{16'h0032, 1'b0, 1'b0}, '{16'h0032, 1'b1, 1'b1}};

  assign step16 = {13'h0000, step};

  always #50 clk = ~clk;

  gsm_operator op_u (.clk(clk), .key_select(k_sel), .key_up(k_up), .key_down(k_dn),
    .relay_disable_n(dis_n), .pressure(p));

  // Short counts keep the run small; every expectation below follows them.
  gsm_menu #(.SEL_HOLD_CYC(20), .DEF_HOLD_CYC(30), .DEB_CYC(3)) dut_u (.clk(clk),
    .reset(reset), .key_select(k_sel), .key_up(k_up), .key_down(k_dn),
    .relay_disable_n(dis_n), .pressure(p), .relay_energize(rly), .display_value(disp),
    .display_step(step), .default_restore_indication(ind), .on_threshold(on_th),
    .off_threshold(off_th), .zero_offset(zero), .span_value(span));

  // --------------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------------
  task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung key sequence would otherwise stall the run forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic tap(input int k, input int n);
    op_u.push(k);
    repeat (n) @(posedge clk);
    op_u.lift(k);
    repeat (14) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic chk_set(input logic [15:0] a, b, c, d);
    chk_val("on_threshold", a, on_th);
    chk_val("off_threshold", b, off_th);
    chk_val("zero_offset", c, zero);
    chk_val("span_value", d, span);
  endtask

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_set(`GSM_DEF_ON_MTORR, `GSM_DEF_OFF_MTORR, `GSM_DEF_ZERO_MTORR, `GSM_DEF_SPAN_TORR);
    chk_bit("relay", 1'b0, rly);
    chk_val("step", 16'h0000, step16);
    chk_val("display", 16'h00FA, disp);
    chk_bit("indication", 1'b0, ind);
    $display("test reset done");
    foreach (rows[i]) begin
      op_u.set_p(rows[i].p);
      op_u.set_dis(rows[i].dis_n);
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk_bit("relay", rows[i].rly, rly);
    end
    $display("test relay done");
    tap(0, 10);
    chk_val("step", 16'h0000, step16);
    tap(0, 40);
    chk_val("step", 16'h0001, step16);
    chk_val("display", `GSM_DEF_ON_MTORR, disp);
    tap(1, 6);
    tap(1, 6);
    chk_val("display", 16'h0066, disp);
    tap(0, 6);
    chk_val("on_threshold", 16'h0066, on_th);
    chk_val("display", `GSM_DEF_OFF_MTORR, disp);
    tap(2, 6);
    tap(0, 6);
    chk_val("off_threshold", 16'h00C7, off_th);
    chk_val("step", 16'h0003, step16);
    chk_val("display", 16'h0000, disp);
    op_u.set_p(16'h0007);
    tap(2, 6);
    chk_val("zero_offset", 16'h0007, zero);
    chk_val("display", `GSM_DEF_SPAN_TORR, disp);
    tap(1, 6);
    chk_val("display", 16'h02F9, disp);
    tap(0, 6);
    chk_val("step", 16'h0000, step16);
    chk_val("span_value", `GSM_DEF_SPAN_TORR, span);
    $display("test first walk done");
    tap(0, 40);
    tap(0, 6);
    tap(0, 6);
    tap(0, 6);
    chk_val("zero_offset", 16'h0007, zero);
    chk_val("step", 16'h0004, step16);
    tap(1, 6);
    // The hold stays short of a second full count: select still held in the
    // normal display after the commit would open setup again.
    tap(0, 30);
    chk_val("span_value", 16'h02F9, span);
    chk_val("step", 16'h0000, step16);
    $display("test span commit done");
    op_u.push(1);
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk_val("step", 16'h0006, step16);
    chk_bit("indication", 1'b1, ind);
    op_u.lift(1);
    repeat (14) @(posedge clk);
    @(negedge clk);
    chk_val("step", 16'h0000, step16);
    chk_set(16'h0066, 16'h00C7, 16'h0007, 16'h02F9);
    tap(1, 45);
    chk_set(`GSM_DEF_ON_MTORR, `GSM_DEF_OFF_MTORR, `GSM_DEF_ZERO_MTORR, `GSM_DEF_SPAN_TORR);
    chk_val("step", 16'h0000, step16);
    $display("test default restore done");
    tap(0, 30);
    tap(1, 6);
    chk_val("display", 16'h0065, disp);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_val("step", 16'h0000, step16);
    chk_val("display", 16'h0007, disp);
    chk_set(`GSM_DEF_ON_MTORR, `GSM_DEF_OFF_MTORR, `GSM_DEF_ZERO_MTORR, `GSM_DEF_SPAN_TORR);
    chk_bit("relay", 1'b1, rly);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule

//--- verilog/gsm_debounce.sv
`timescale 1ns/100ps
`include "gsm_params.svh"

module gsm_debounce #(
  parameter int unsigned DEB_CYC = `GSM_DEB_MS * `GSM_CYC_PER_MS,
  parameter logic RST_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);

  // --------------------------------------------------------------------------
  // Synchroniser and stability filter
  // --------------------------------------------------------------------------
  logic sync1_reg, sync2_reg, sync3_reg;
  logic level_reg, level_next;
  logic [`GSM_DEB_W-1:0] cnt_reg, cnt_next;

  // A change is only timed while the last two stages agree, so a sample
  // caught mid-transition never starts the stability count.
  always_comb begin
    level_next = level_reg;
    cnt_next = '0;
    if (sync2_reg == sync3_reg && sync3_reg != level_reg) begin
      if (cnt_reg == `GSM_DEB_W'(DEB_CYC - 1)) begin
        level_next = sync3_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= RST_LEVEL;
      sync2_reg <= RST_LEVEL;
      sync3_reg <= RST_LEVEL;
      level_reg <= RST_LEVEL;
      cnt_reg <= '0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
    end
  end

  assign level = level_reg;

endmodule

//--- verilog/gsm_menu.sv
`timescale 1ns/100ps
`include "gsm_params.svh"

module gsm_menu
  import gsm_pkg::*;
#(
  parameter int unsigned SEL_HOLD_CYC = `GSM_SEL_HOLD_MS * `GSM_CYC_PER_MS,
  parameter int unsigned DEF_HOLD_CYC = `GSM_DEF_HOLD_MS * `GSM_CYC_PER_MS,
  parameter int unsigned DEB_CYC = `GSM_DEB_MS * `GSM_CYC_PER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic key_select,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic relay_disable_n,
  input wire logic [`GSM_VAL_W-1:0] pressure,
  output logic relay_energize,
  output logic [`GSM_VAL_W-1:0] display_value,
  output logic [2:0] display_step,
  output logic default_restore_indication,
  output logic [`GSM_VAL_W-1:0] on_threshold,
  output logic [`GSM_VAL_W-1:0] off_threshold,
  output logic [`GSM_VAL_W-1:0] zero_offset,
  output logic [`GSM_VAL_W-1:0] span_value
);

  // --------------------------------------------------------------------------
  // Key and disable conditioning
  // --------------------------------------------------------------------------
  logic sel_db, up_db, down_db, dis_n_db;
  logic sel_prev_reg, up_prev_reg, down_prev_reg;
  logic sel_rise, sel_fall, up_rise, down_rise;

  gsm_debounce #(.DEB_CYC(DEB_CYC)) u_sel (
    .clk(clk), .reset(reset), .pin(key_select), .level(sel_db)
  );
  gsm_debounce #(.DEB_CYC(DEB_CYC)) u_up (
    .clk(clk), .reset(reset), .pin(key_up), .level(up_db)
  );
  gsm_debounce #(.DEB_CYC(DEB_CYC)) u_down (
    .clk(clk), .reset(reset), .pin(key_down), .level(down_db)
  );
  // The disable line is treated as released at reset so the relay follows
  // pressure straight out of reset, before the filter has seen the real pin level.
  gsm_debounce #(.DEB_CYC(DEB_CYC), .RST_LEVEL(1'b1)) u_dis (
    .clk(clk), .reset(reset), .pin(relay_disable_n), .level(dis_n_db)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_prev_reg <= 1'b0;
      up_prev_reg <= 1'b0;
      down_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_db;
      up_prev_reg <= up_db;
      down_prev_reg <= down_db;
    end
  end

  assign sel_rise = sel_db && !sel_prev_reg;
  assign sel_fall = !sel_db && sel_prev_reg;
  assign up_rise = up_db && !up_prev_reg;
  assign down_rise = down_db && !down_prev_reg;

  // --------------------------------------------------------------------------
  // Menu sequencer
  // --------------------------------------------------------------------------
  gsm_state_t state_reg, state_next;
  logic [`GSM_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`GSM_VAL_W-1:0] cand_reg, cand_next;
  logic [`GSM_VAL_W-1:0] on_reg, on_next, off_reg, off_next;
  logic [`GSM_VAL_W-1:0] zero_reg, zero_next, span_reg, span_next;
  logic [`GSM_VAL_W-1:0] disp_reg, disp_next;
  logic hold_key;
  logic sel_done, def_done;

  // Saturating one-step adjust; up wins when both keys land together.
  function automatic logic [`GSM_VAL_W-1:0] adjust(
    input logic [`GSM_VAL_W-1:0] v,
    input logic inc,
    input logic dec
  );
    logic [`GSM_VAL_W-1:0] r;
    r = v;
    if (inc && v != `GSM_VAL_MAX) begin
      r = v + `GSM_VAL_STEP;
    end else if (dec && !inc && v != `GSM_VAL_ZERO) begin
      r = v - `GSM_VAL_STEP;
    end
    return r;
  endfunction

  always_comb begin
    unique case (state_reg)
      GSM_NORMAL: hold_key = sel_db;
      GSM_SPAN_HOLD: hold_key = sel_db;
      GSM_DEF_HOLD: hold_key = up_db;
      default: hold_key = 1'b0;
    endcase
  end

  assign sel_done = sel_db && cnt_reg == `GSM_CNT_W'(SEL_HOLD_CYC - 1);
  assign def_done = up_db && cnt_reg == `GSM_CNT_W'(DEF_HOLD_CYC - 1);

  always_comb begin
    state_next = state_reg;
    cand_next = cand_reg;
    on_next = on_reg;
    off_next = off_reg;
    zero_next = zero_reg;
    span_next = span_reg;
    cnt_next = hold_key ? cnt_reg + 1'b1 : '0;
    unique case (state_reg)
      GSM_NORMAL: begin
        if (sel_done) begin
          state_next = GSM_ON_TH;
          cand_next = on_reg;
          cnt_next = '0;
        end else if (up_rise && !sel_db) begin
          state_next = GSM_DEF_HOLD;
          cnt_next = '0;
        end
      end
      GSM_ON_TH: begin
        if (sel_rise) begin
          on_next = cand_reg;
          cand_next = off_reg;
          state_next = GSM_OFF_TH;
        end else begin
          cand_next = adjust(cand_reg, up_rise, down_rise);
        end
      end
      GSM_OFF_TH: begin
        if (sel_rise) begin
          off_next = cand_reg;
          state_next = GSM_ZERO;
        end else begin
          cand_next = adjust(cand_reg, up_rise, down_rise);
        end
      end
      GSM_ZERO: begin
        if (down_rise) begin
          zero_next = pressure;
          cand_next = span_reg;
          state_next = GSM_SPAN;
        end else if (sel_rise) begin
          cand_next = span_reg;
          state_next = GSM_SPAN;
        end
      end
      GSM_SPAN: begin
        if (sel_rise) begin
          state_next = GSM_SPAN_HOLD;
        end else begin
          cand_next = adjust(cand_reg, up_rise, down_rise);
        end
      end
      GSM_SPAN_HOLD: begin
        if (sel_done) begin
          span_next = cand_reg;
          state_next = GSM_NORMAL;
          cnt_next = '0;
        end else if (!sel_db) begin
          state_next = GSM_NORMAL;
        end
      end
      GSM_DEF_HOLD: begin
        if (def_done) begin
          on_next = `GSM_DEF_ON_MTORR;
          off_next = `GSM_DEF_OFF_MTORR;
          zero_next = `GSM_DEF_ZERO_MTORR;
          span_next = `GSM_DEF_SPAN_TORR;
          state_next = GSM_NORMAL;
          cnt_next = '0;
        end else if (!up_db) begin
          state_next = GSM_NORMAL;
        end
      end
      default: begin
        state_next = GSM_NORMAL;
      end
    endcase
  end

  // The readout shows the candidate in the threshold and span steps and 000 in the zero step; it is
  // chosen from the next step, so on commit it switches to pressure in the same cycle as the step.
  always_comb begin
    unique case (state_next)
      GSM_ZERO: disp_next = `GSM_VAL_ZERO;
      GSM_ON_TH, GSM_OFF_TH, GSM_SPAN, GSM_SPAN_HOLD: disp_next = cand_next;
      default: disp_next = pressure;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= GSM_NORMAL;
      cnt_reg <= '0;
      cand_reg <= `GSM_VAL_ZERO;
      on_reg <= `GSM_DEF_ON_MTORR;
      off_reg <= `GSM_DEF_OFF_MTORR;
      zero_reg <= `GSM_DEF_ZERO_MTORR;
      span_reg <= `GSM_DEF_SPAN_TORR;
      disp_reg <= `GSM_VAL_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cand_reg <= cand_next;
      on_reg <= on_next;
      off_reg <= off_next;
      zero_reg <= zero_next;
      span_reg <= span_next;
      disp_reg <= disp_next;
    end
  end

  // --------------------------------------------------------------------------
  // Setpoint relay
  // --------------------------------------------------------------------------
  logic relay_reg, relay_next;

  // If a user sets turn-on above turn-off, below-on wins, so the relay never
  // chatters inside the overlap; it simply stays energized there.
  always_comb begin
    relay_next = relay_reg;
    if (!dis_n_db) begin
      relay_next = 1'b0;
    end else if (pressure < on_reg) begin
      relay_next = 1'b1;
    end else if (pressure > off_reg) begin
      relay_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      relay_reg <= 1'b0;
    end else begin
      relay_reg <= relay_next;
    end
  end

  assign relay_energize = relay_reg;
  assign display_value = disp_reg;
  assign display_step = state_reg;
  assign default_restore_indication = (state_reg == GSM_DEF_HOLD);
  assign on_threshold = on_reg;
  assign off_threshold = off_reg;
  assign zero_offset = zero_reg;
  assign span_value = span_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  enter_setup_a: assert property (
    (state_reg == GSM_NORMAL && state_next == GSM_ON_TH)
      |-> sel_db && cnt_reg == `GSM_CNT_W'(SEL_HOLD_CYC - 1))
    else $error("Setup entered without a full select hold.");
  relay_below_a: assert property (
    dis_n_db && pressure < on_reg |=> relay_energize)
    else $error("Relay not energized below turn-on.");
  relay_above_a: assert property (
    dis_n_db && pressure >= on_reg && pressure > off_reg |=> !relay_energize)
    else $error("Relay not released above turn-off.");
  store_on_a: assert property (
    state_reg == GSM_ON_TH && sel_rise
      |=> on_threshold == $past(cand_reg) && state_reg == GSM_OFF_TH)
    else $error("Turn-on value not stored on select.");
  zero_show_a: assert property (
    state_reg == GSM_ZERO ##1 state_reg == GSM_ZERO |-> display_value == `GSM_VAL_ZERO)
    else $error("Zero step readout is not 000.");
  zero_capture_a: assert property (
    state_reg == GSM_ZERO && down_rise
      |=> zero_offset == $past(pressure) && state_reg == GSM_SPAN)
    else $error("Zero not captured on down.");
  span_load_a: assert property (
    state_reg == GSM_ZERO && state_next == GSM_SPAN |=> cand_reg == span_value)
    else $error("Span step does not start from stored span.");
  span_brief_a: assert property (
    state_reg == GSM_SPAN_HOLD && !sel_db
      |=> state_reg == GSM_NORMAL && $stable(span_value))
    else $error("Brief select changed span or stayed in setup.");
  span_commit_a: assert property (
    state_reg == GSM_SPAN_HOLD && sel_done
      |=> span_value == $past(cand_reg) && state_reg == GSM_NORMAL)
    else $error("Held select did not commit the span.");
  disable_relay_a: assert property (
    !dis_n_db |=> !relay_energize)
    else $error("Relay active while disabled.");
  default_restore_a: assert property (
    state_reg == GSM_DEF_HOLD && def_done |=> on_threshold == `GSM_DEF_ON_MTORR
      && span_value == `GSM_DEF_SPAN_TORR && state_reg == GSM_NORMAL)
    else $error("Factory defaults not restored.");
  relay_band_a: assert property (
    dis_n_db && pressure >= on_reg && pressure <= off_reg |=> $stable(relay_energize))
    else $error("Relay changed inside the hysteresis band.");

  setup_entry_c: cover property (state_reg == GSM_NORMAL ##1 state_reg == GSM_ON_TH);
  span_commit_c: cover property (state_reg == GSM_SPAN_HOLD && sel_done);
  default_done_c: cover property (state_reg == GSM_DEF_HOLD && def_done);
  relay_on_c: cover property (!relay_energize ##1 relay_energize);

endmodule

//--- verilog/gsm_params.svh
`ifndef GSM_PARAMS_SVH
`define GSM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GSM_CLK_NS 32'h0000_0064
`define GSM_NS_PER_MS 32'h000F_4240
`define GSM_CYC_PER_MS (`GSM_NS_PER_MS / `GSM_CLK_NS)
`define GSM_SEL_HOLD_MS 32'h0000_0BB8
`define GSM_DEF_HOLD_MS 32'h0000_1388
`define GSM_DEB_MS 32'h0000_0014
`define GSM_CNT_W 26
`define GSM_DEB_W 20

// ----------------------------------------------------------------------------
// Values and factory defaults
// ----------------------------------------------------------------------------
`define GSM_VAL_W 16
`define GSM_VAL_MAX 16'hFFFF
`define GSM_VAL_ZERO 16'h0000
`define GSM_VAL_STEP 16'h0001
`define GSM_DEF_ON_MTORR 16'h0064
`define GSM_DEF_OFF_MTORR 16'h00C8
`define GSM_DEF_ZERO_MTORR 16'h0000
`define GSM_DEF_SPAN_TORR 16'h02F8

`endif

//--- verilog/gsm_pkg.sv
package gsm_pkg;

  // Setup menu steps; the code is also presented on the display step port.
  typedef enum logic [2:0] {
    GSM_NORMAL = 3'b000,
    GSM_ON_TH = 3'b001,
    GSM_OFF_TH = 3'b010,
    GSM_ZERO = 3'b011,
    GSM_SPAN = 3'b100,
    GSM_SPAN_HOLD = 3'b101,
    GSM_DEF_HOLD = 3'b110
  } gsm_state_t;

endpackage
